//--- include/wdtcg_pkg.sv
// Package for the watchdog and clock gating block: map, fields, timing
package wdtcg_pkg;
	// I/O map
	localparam logic [7:0] WDTCG_ADDR_CLEAR = 8'hd4;
	localparam int WDTCG_BIT_TB_CLEAR = 0;
	localparam int WDTCG_BIT_WD_CLEAR = 1;
	localparam logic [3:0] WDTCG_CLEAR_READ = 4'h0;
	// Oscillator and timebase
	localparam int WDTCG_OSC_HZ = 32768;
	localparam int WDTCG_TB_WIDTH = 15;
	localparam int WDTCG_WD_WIDTH = 2;
	localparam logic [1:0] WDTCG_WD_LAST = 2'h3;
	// Instruction lengths in oscillator cycles
	localparam logic [3:0] WDTCG_INSN_SHORT = 4'h5;
	localparam logic [3:0] WDTCG_INSN_MID = 4'h7;
	localparam logic [3:0] WDTCG_INSN_LONG = 4'hc;
	// Power-on startup hold in mclk cycles
	localparam logic [3:0] WDTCG_POR_CYCLES = 4'h4;
	typedef enum logic [1:0] {WDTCG_CLS_SHORT, WDTCG_CLS_MID, WDTCG_CLS_LONG} wdtcg_cls_t;
endpackage : wdtcg_pkg

//--- hw/wdtcg_core.sv
// Watchdog, clock timer divider, startup and sleep clock gating
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
module wdtcg_core
	import wdtcg_pkg::*;
(
	// Clock and reset
	input wire logic mclk,
	input wire logic srst,
	// Oscillator tick, one pulse per crystal period
	input wire logic osc_tick,
	// External reset pin level
	input wire logic reset_pin,
	// CPU I/O access
	input wire logic [7:0] io_addr,
	input wire logic [3:0] io_wdata,
	input wire logic io_wr,
	input wire logic io_rd,
	output logic [3:0] io_rdata,
	output logic io_hit,
	// CPU state
	input wire logic sleep_instruction,
	input wire logic wake,
	input wire logic halted,
	input wire wdtcg_cls_t insn_class,
	// Outputs to CPU and peripherals
	output logic initial_reset,
	output logic cpu_clk_en,
	output logic periph_clk_en,
	output logic insn_done,
	output logic [7:0] timebase_data
);

	////////////////////////////////////////////////////////////////////////////
	// State layout
	// All state sits in one record so that the reset branch and the
	// next-state logic cannot drift apart when a field is added.
	// The timebase is a plain binary divider of oscillator ticks; its top
	// bit is the 1 Hz tap that both steps the watchdog and opens the CPU
	// clock after reset or wake.
	// The watchdog is only two bits wide, so it fires on the fourth tap
	// rise after a clear; depending on the phase of the clear against the
	// tap this gives a window between three and four seconds.
	// Limitation: a clear written just after a tap rise buys almost four
	// seconds, one written just before buys barely three, so software
	// must budget for the short case.
	// Trade-off: the power-on hold is a short fixed count rather than a
	// model of oscillator start-up, which keeps the reset path simple.
	// Sleep clears and stops the divider and watchdog together, so the two can
	// never disagree about elapsed time when the CPU wakes.
	typedef struct packed {
		logic [3:0] por_cnt;
		logic [WDTCG_TB_WIDTH-1:0] tb;
		logic [WDTCG_WD_WIDTH-1:0] wd;
		logic tap_prev;
		logic in_reset;
		logic clk_ok;
		logic sleeping;
		logic [3:0] cyc;
		logic done;
	} wdtcg_state_t;

	wdtcg_state_t s_q;
	wdtcg_state_t s_d;

	// Cycle count of the current instruction class
	function automatic logic [3:0] insn_len(input wdtcg_cls_t c);
		case (c)
			WDTCG_CLS_SHORT: insn_len = WDTCG_INSN_SHORT;
			WDTCG_CLS_MID: insn_len = WDTCG_INSN_MID;
			WDTCG_CLS_LONG: insn_len = WDTCG_INSN_LONG;
			default: insn_len = WDTCG_INSN_SHORT;
		endcase
	endfunction : insn_len

	logic tap_1hz;
	logic clr_wr;
	logic wd_clr;
	logic tb_clr;
	logic tick_en;
	logic wd_fire;

	////////////////////////////////////////////////////////////////////////////
	// Decode and timebase tap
	assign tap_1hz = s_q.tb[WDTCG_TB_WIDTH-1];
	assign clr_wr = io_wr && (io_addr == WDTCG_ADDR_CLEAR);
	assign tb_clr = clr_wr && io_wdata[WDTCG_BIT_TB_CLEAR];
	assign wd_clr = tb_clr || (clr_wr && io_wdata[WDTCG_BIT_WD_CLEAR]);
	// Halt does not gate this; only sleep does
	assign tick_en = osc_tick && !s_q.sleeping;
	assign wd_fire = tick_en && tap_1hz && !s_q.tap_prev && (s_q.wd == WDTCG_WD_LAST);

	////////////////////////////////////////////////////////////////////////////
	// Next state
	always_comb
	begin
		s_d = s_q;
		s_d.done = 1'b0;
		// Power-on hold; oscillator itself needs no enable
		if (s_q.por_cnt != 4'h0)
		begin
			s_d.por_cnt = s_q.por_cnt - 4'h1;
		end
		if (tick_en)
		begin
			s_d.tb = s_q.tb + 15'h0001;
			s_d.tap_prev = tap_1hz;
			// 1 Hz rising edge steps the watchdog
			if (tap_1hz && !s_q.tap_prev)
			begin
				s_d.wd = s_q.wd + 2'h1;
			end
		end
		// Overflow raises reset and clears the counter
		if (wd_fire)
		begin
			s_d.in_reset = 1'b1;
			s_d.wd = '0;
			s_d.tb = '0;
			s_d.tap_prev = 1'b0;
		end
		if (wd_clr)
		begin
			s_d.wd = '0;
		end
		if (tb_clr)
		begin
			s_d.tb = '0;
			s_d.tap_prev = 1'b0;
		end
		// Sleep entry clears both counters and stops them
		if (sleep_instruction && !s_q.sleeping)
		begin
			s_d.sleeping = 1'b1;
			s_d.wd = '0;
			s_d.tb = '0;
			s_d.tap_prev = 1'b0;
		end
		else if (wake && s_q.sleeping)
		begin
			s_d.sleeping = 1'b0;
			s_d.clk_ok = 1'b0;
		end
		// External pin holds everything in initial reset
		if (reset_pin)
		begin
			s_d.in_reset = 1'b1;
			s_d.wd = '0;
			s_d.tb = '0;
			s_d.tap_prev = 1'b0;
			s_d.sleeping = 1'b0;
		end
		else if (s_q.in_reset && !wd_fire)
		begin
			s_d.in_reset = 1'b0;
			s_d.clk_ok = 1'b0;
		end
		// CPU clock waits for 1 Hz tap high after reset or wake
		if (!s_q.in_reset && !s_q.sleeping && tap_1hz)
		begin
			s_d.clk_ok = 1'b1;
		end
		// Instruction sequencer in oscillator cycles
		if (cpu_clk_en && !halted && osc_tick)
		begin
			if (s_q.cyc + 4'h1 >= insn_len(insn_class))
			begin
				s_d.cyc = 4'h0;
				s_d.done = 1'b1;
			end
			else
			begin
				s_d.cyc = s_q.cyc + 4'h1;
			end
		end
		if (!cpu_clk_en)
		begin
			s_d.cyc = 4'h0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// State register
	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			s_q <= '{por_cnt: WDTCG_POR_CYCLES, in_reset: 1'b1, default: '0};
		end
		else
		begin
			s_q <= s_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Outputs
	assign initial_reset = s_q.in_reset || (s_q.por_cnt != 4'h0);
	assign cpu_clk_en = s_q.clk_ok && !initial_reset && !s_q.sleeping;
	assign periph_clk_en = !s_q.sleeping;
	assign insn_done = s_q.done;
	assign timebase_data = s_q.tb[WDTCG_TB_WIDTH-1:WDTCG_TB_WIDTH-8];
	assign io_hit = io_rd && (io_addr == WDTCG_ADDR_CLEAR);
	// Write-only word, always zero on read
	assign io_rdata = WDTCG_CLEAR_READ;

endmodule : wdtcg_core

`default_nettype wire

//--- tb/wdtcg_core_properties.sv
// Port checker for the watchdog and clock gating core
`timescale 1ns/1ps
`default_nettype none
module wdtcg_props
	import wdtcg_pkg::*;
(
	// Watched ports
	input wire logic mclk,
	input wire logic srst,
	input wire logic reset_pin,
	input wire logic [7:0] io_addr,
	input wire logic [3:0] io_wdata,
	input wire logic io_wr,
	input wire logic io_rd,
	input wire logic [3:0] io_rdata,
	input wire logic io_hit,
	input wire logic sleep_instruction,
	input wire logic initial_reset,
	input wire logic cpu_clk_en,
	input wire logic periph_clk_en,
	input wire logic insn_done,
	input wire logic [7:0] timebase_data
);
	default clocking @(posedge mclk); endclocking
	default disable iff (srst);
	// Timebase copy may lag a cycle, so clears allow two edges
	a_read_zero: assert property (io_rd |-> io_rdata == 4'h0) else $error("rdata");
	a_tb_clear: assert property (io_wr && io_addr == 8'hd4 && io_wdata[0]
		|-> ##2 timebase_data == 8'h0) else $error("tb clear");
	a_sleep_clear: assert property (sleep_instruction
		|=> !periph_clk_en ##1 timebase_data == 8'h0) else $error("sleep");
	a_sleep_stop: assert property (!periph_clk_en [*3] |-> $stable(timebase_data)) else $error("run");
	a_cpu_wait: assert property ($rose(cpu_clk_en) |-> ##[0:1] timebase_data[7]) else $error("en");
	a_reset_gate: assert property ($rose(initial_reset) |=> !cpu_clk_en) else $error("gate");
	a_wd_pulse: assert property ($rose(initial_reset) && !reset_pin |=> !initial_reset) else $error("ir");
	a_ovf_restart: assert property ($fell(initial_reset) |-> timebase_data == 8'h0) else $error("ovf");
	a_insn_gap: assert property (insn_done |=> !insn_done [*4]) else $error("insn");
	a_hit_decode: assert property (io_hit == (io_rd && io_addr == 8'hd4)) else $error("hit");
	// Main scenarios
	c_overflow: cover property ($rose(initial_reset));
	c_sleep: cover property ($fell(periph_clk_en));
	c_run: cover property ($rose(cpu_clk_en));
endmodule : wdtcg_props
bind wdtcg_core wdtcg_props u_props (.*);
`default_nettype wire

//--- tb/wdtcg_cpu_model.sv
// Processor core model issuing I/O accesses to the clear word
`timescale 1ns/1ps
`default_nettype none
module wdtcg_cpu_model (
	// Clock and I/O bus
	input wire logic mclk,
	input wire logic [3:0] io_rdata,
	output logic [7:0] io_addr,
	output logic [3:0] io_wdata,
	output logic io_wr,
	output logic io_rd
);
	// Bus starts idle
	initial {io_addr, io_wdata, io_wr, io_rd} = 14'h0;
	// One-cycle strobe; released bus shows inverted address and data with both strobes low, never stale values
	task automatic acc(input logic w, input logic [7:0] a, input logic [3:0] d, output logic [3:0] q);
		@(posedge mclk) #1;
		{io_addr, io_wdata, io_wr, io_rd} = {a, d, w, !w};
		@(posedge mclk) q = io_rdata;
		#1 {io_addr, io_wdata, io_wr, io_rd} = {~a, ~d, 2'b00};
	endtask : acc
endmodule : wdtcg_cpu_model
`default_nettype wire

//--- tb/tb_watchdog_and_clock_gating.sv
// Self-checking bench for the watchdog and clock gating core
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin num_errors++; \
	$display("[ERR] %0t mismatch", $time); end end
module tb_watchdog_and_clock_gating;
	import wdtcg_pkg::*;
	logic mclk = 1'b0, srst = 1'b1, osc_tick = 1'b1, reset_pin = 1'b0;
	logic sleep_instruction = 1'b0, wake = 1'b0, halted = 1'b0;
	wdtcg_cls_t insn_class = WDTCG_CLS_SHORT;
	logic [7:0] io_addr, timebase_data;
	logic [3:0] io_wdata, io_rdata, q;
	logic io_wr, io_rd, io_hit, initial_reset, cpu_clk_en, periph_clk_en, insn_done;
	logic [3:0] lens [3] = '{WDTCG_INSN_SHORT, WDTCG_INSN_MID, WDTCG_INSN_LONG};
	int num_errors = 0, comparisons = 0, cycles = 0, n, c0;
	wdtcg_core DUT (.*);
	wdtcg_cpu_model cpu (.*);
	// Clock and hang ceiling; one second is 32768 ticks, so the run is long
	always #20 mclk = ~mclk;
	always @(posedge mclk) if (++cycles > 120000) begin num_errors++; report_and_stop(); end
	task automatic step(input int k);
		repeat (k) @(posedge mclk);
		#1;
	endtask : step
	task automatic report_and_stop();
		if (num_errors == 0 && comparisons > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : report_and_stop
	// Main sequence
	initial
	begin
		step(6);
		`CHK({initial_reset, cpu_clk_en}, 2'b10)
		srst = 1'b0;
		cpu.acc(1'b0, 8'hd4, 4'h0, q);
		`CHK(q, 4'h0)
		// Sleep first, so the startup wait and the overflow window overlap
		step(300);
		sleep_instruction = 1'b1;
		step(1);
		sleep_instruction = 1'b0;
		step(200);
		`CHK({periph_clk_en, timebase_data}, 9'h000)
		wake = 1'b1;
		step(1);
		wake = 1'b0;
		step(1);
		`CHK({periph_clk_en, cpu_clk_en}, 2'b10)
		step(300);
		cpu.acc(1'b1, 8'hd4, 4'h0, q);
		cpu.acc(1'b1, 8'hd5, 4'h1, q);
		`CHK(timebase_data != 8'h00, 1'b1)
		cpu.acc(1'b1, 8'hd4, 4'h1, q);
		c0 = cycles;
		step(1);
		`CHK(timebase_data, 8'h00)
		for (n = 0; n < 17000 && cpu_clk_en !== 1'b1; n++) step(1);
		`CHK(n inside {[16370:16390]}, 1'b1)
		foreach (lens[i])
		begin
			insn_class = wdtcg_cls_t'(i);
			repeat (3)
			begin
				for (n = 1; n < 20 && insn_done !== 1'b1; n++) step(1);
				step(1);
			end
			`CHK(n, int'(lens[i]))
		end
		`CHK(timebase_data[7], 1'b1)
		// Overflow window of 3 to 4 seconds counted from the combined clear
		halted = 1'b1;
		for (n = 0; n < 132000 && initial_reset !== 1'b1; n++) step(1);
		`CHK((cycles - c0) inside {[98304:131072]}, 1'b1)
		step(1);
		`CHK({initial_reset, timebase_data}, 9'h000)
		report_and_stop();
	end
endmodule : tb_watchdog_and_clock_gating
`default_nettype wire
